// >>> include/ofs_defines.svh
// constants for the optical module fault and status block
`ifndef OFS_DEFINES_SVH
`define OFS_DEFINES_SVH

// two-wire slave address of the diagnostic page (8-bit form, r/w bit zero)
`define OFS_DEV_ADDR      8'ha2
// control and status byte offset and its fields
`define OFS_CTRL_STAT_OFS 8'h6e
`define OFS_BIT_TX_PIN    7
`define OFS_BIT_SOFT_OFF  6
`define OFS_BIT_TX_FAULT  2
`define OFS_BIT_RX_LOST   1
`define OFS_SOFT_OFF_RST  1'b0
`define OFS_PTR_RST       8'h00
// factory detection threshold on received level
`define OFS_RX_LOST_THR   8'h20
// least spacing of shutoff assertions the host keeps
`define OFS_TX_OFF_GAP_MS 10

`endif

// >>> include/ofs_pkg.sv
// types for the optical module fault and status block
package ofs_pkg;

  typedef enum logic [3:0] {
    OFS_IDLE,
    OFS_ADDR,
    OFS_ADDR_ACK,
    OFS_PTR,
    OFS_PTR_ACK,
    OFS_WR,
    OFS_WR_ACK,
    OFS_RD,
    OFS_RD_ACK
  } ofs_tw_state_t;

endpackage

// >>> rtl/ofs_fault_status.sv
// fault latch, shutoff, loss of signal and two-wire status byte
// How it works
// - a catastrophic laser fault raises the fault flag and stops the laser.
// - fault flag pin is low in normal operation, high during a fault.
// - fault flag stays latched until shutoff is toggled or power cycles.
// - fault state appears in bit 2 of status byte 110.
// - eye-safety monitor disables the transmitter whenever output is unsafe.
// - signal lost output is low for adequate input, high for unusable input.
// - signal lost state appears in bit 1 of status byte 110.
// - signal lost is high after reset, and otherwise only below the factory set detection threshold.
// - shutoff input high turns optical output off, low allows operation.
// - software shutoff bit 6 is ORed with the shutoff input.
// - bit 7 of status byte 110 reflects the shutoff input.
`timescale 1ns/10ps
`include "ofs_defines.svh"

module ofs_fault_status
  import ofs_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // host control pin
  input  wire logic       tx_disable_pin,
  // internal monitors
  input  wire logic       laser_fault_det,
  input  wire logic       eye_unsafe,
  input  wire logic [7:0] rx_level,
  // laser drive
  output logic            laser_enable,
  // fault flag pin, open drain
  output logic            tx_fault_out,
  output logic            tx_fault_oe_n,
  // receive status pin
  output logic            receive_signal_lost,
  // two-wire management pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n
);

  logic          fault_q;
  logic          armed_q;
  logic          soft_off_q;
  logic          los_q;
  logic          tx_off;
  logic          fault_evt;
  logic          clear_ok;
  logic [7:0]    stat_byte;
  logic          scl_p_q;
  logic          sda_p_q;
  logic          scl_rise;
  logic          scl_fall;
  logic          tw_start;
  logic          tw_stop;
  ofs_tw_state_t state_q;
  logic [3:0]    cnt_q;
  logic [7:0]    sh_q;
  logic [7:0]    ptr_q;
  logic          rw_q;
  logic          nack_q;

  assign tx_off    = tx_disable_pin | soft_off_q;
  assign fault_evt = laser_fault_det | eye_unsafe;
  assign clear_ok  = armed_q & ~tx_off;

  // transmitter stops at once on any fault, shutoff or unsafe output
  assign laser_enable = ~tx_off & ~fault_q & ~fault_evt;

  // open drain: pull low while healthy, release high on fault
  assign tx_fault_out  = 1'b0;
  assign tx_fault_oe_n = fault_q;

  assign receive_signal_lost = los_q;

  // fault latch; a new event wins over the clearing toggle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_q <= 1'b0;
    end else if (fault_evt) begin
      fault_q <= 1'b1;
    end else if (clear_ok) begin
      fault_q <= 1'b0;
    end
  end

  // toggle tracker: armed by shutoff asserted during a fault
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else if (clear_ok) begin
      armed_q <= 1'b0;
    end else if (fault_q & tx_off) begin
      armed_q <= 1'b1;
    end
  end

  // loss of signal against the factory threshold
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      los_q <= 1'b1;
    end else begin
      los_q <= (rx_level < `OFS_RX_LOST_THR);
    end
  end

  always_comb begin
    stat_byte                    = 8'h00;
    stat_byte[`OFS_BIT_TX_PIN]   = tx_disable_pin;
    stat_byte[`OFS_BIT_SOFT_OFF] = soft_off_q;
    stat_byte[`OFS_BIT_TX_FAULT] = fault_q;
    stat_byte[`OFS_BIT_RX_LOST]  = los_q;
  end

  // two-wire line edges and bus conditions
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_in;
      sda_p_q <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_p_q;
  assign scl_fall = ~scl_in & scl_p_q;
  assign tw_start = scl_in & scl_p_q & sda_p_q & ~sda_in;
  assign tw_stop  = scl_in & scl_p_q & ~sda_p_q & sda_in;

  // two-wire slave sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= OFS_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      ptr_q   <= `OFS_PTR_RST;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
    end else if (tw_start) begin
      state_q <= OFS_ADDR;
      cnt_q   <= 4'h0;
    end else if (tw_stop) begin
      state_q <= OFS_IDLE;
    end else if (scl_rise) begin
      if (state_q == OFS_ADDR || state_q == OFS_PTR || state_q == OFS_WR) begin
        sh_q  <= {sh_q[6:0], sda_in};
        cnt_q <= cnt_q + 4'h1;
      end else if (state_q == OFS_RD_ACK) begin
        nack_q <= sda_in;
      end
    end else if (scl_fall) begin
      unique case (state_q)
        OFS_IDLE: begin
        end
        OFS_ADDR: begin
          if (cnt_q == 4'h8) begin
            rw_q    <= sh_q[0];
            state_q <= (sh_q[7:1] == 7'(`OFS_DEV_ADDR >> 1)) ? OFS_ADDR_ACK : OFS_IDLE;
          end
        end
        OFS_ADDR_ACK: begin
          cnt_q <= 4'h0;
          if (rw_q) begin
            sh_q    <= (ptr_q == `OFS_CTRL_STAT_OFS) ? stat_byte : 8'h00;
            state_q <= OFS_RD;
          end else begin
            state_q <= OFS_PTR;
          end
        end
        OFS_PTR: begin
          if (cnt_q == 4'h8) begin
            ptr_q   <= sh_q;
            state_q <= OFS_PTR_ACK;
          end
        end
        OFS_PTR_ACK: begin
          cnt_q   <= 4'h0;
          state_q <= OFS_WR;
        end
        OFS_WR: begin
          if (cnt_q == 4'h8) begin
            ptr_q   <= ptr_q + 8'h01;
            state_q <= OFS_WR_ACK;
          end
        end
        OFS_WR_ACK: begin
          cnt_q   <= 4'h0;
          state_q <= OFS_WR;
        end
        OFS_RD: begin
          if (cnt_q == 4'h7) begin
            ptr_q   <= ptr_q + 8'h01;
            state_q <= OFS_RD_ACK;
          end else begin
            sh_q  <= {sh_q[6:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
          end
        end
        OFS_RD_ACK: begin
          cnt_q <= 4'h0;
          if (nack_q) begin
            state_q <= OFS_IDLE;
          end else begin
            sh_q    <= (ptr_q == `OFS_CTRL_STAT_OFS) ? stat_byte : 8'h00;
            state_q <= OFS_RD;
          end
        end
        default: begin
          state_q <= OFS_IDLE;
        end
      endcase
    end
  end

  // software shutoff bit, written by a data byte to the status offset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_off_q <= `OFS_SOFT_OFF_RST;
    end else if (scl_fall && state_q == OFS_WR && cnt_q == 4'h8 && ptr_q == `OFS_CTRL_STAT_OFS) begin
      soft_off_q <= sh_q[`OFS_BIT_SOFT_OFF];
    end
  end

  // pull data low for acks and zero read bits
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~((state_q == OFS_ADDR_ACK) || (state_q == OFS_PTR_ACK) ||
                      (state_q == OFS_WR_ACK) || (state_q == OFS_RD && !sh_q[7]));

  // checks
  sequence s_fault_clears;
    fault_q ##1 !fault_q;
  endsequence

  property p_fault_sets;
    @(posedge clk) disable iff (sys_rst) laser_fault_det |=> fault_q && tx_fault_oe_n;
  endproperty
  a_fault_sets: assert property (p_fault_sets) else $error("fault not latched");

  property p_fault_pin;
    @(posedge clk) disable iff (sys_rst) !fault_q && !fault_evt ##1 !fault_evt |-> !tx_fault_oe_n;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin not low when healthy");

  property p_fault_holds;
    @(posedge clk) disable iff (sys_rst) fault_q && !armed_q |=> fault_q;
  endproperty
  a_fault_holds: assert property (p_fault_holds) else $error("fault cleared without toggle");

  property p_stat_fault;
    @(posedge clk) disable iff (sys_rst) stat_byte[2] == fault_q && stat_byte[1] == los_q;
  endproperty
  a_stat_fault: assert property (p_stat_fault) else $error("status bits mismatch");

  property p_eye;
    @(posedge clk) disable iff (sys_rst) eye_unsafe |-> !laser_enable ##1 fault_q;
  endproperty
  a_eye: assert property (p_eye) else $error("unsafe output not shut off");

  property p_los;
    @(posedge clk) disable iff (sys_rst) (rx_level >= `OFS_RX_LOST_THR) |=> !receive_signal_lost;
  endproperty
  a_los: assert property (p_los) else $error("signal lost without threshold");

  property p_resume;
    @(posedge clk) disable iff (sys_rst) s_fault_clears |-> $past(tx_off) == 1'b0 && $past(armed_q) && !$past(fault_evt);
  endproperty
  a_resume: assert property (p_resume) else $error("fault cleared without toggle");

  property p_shutoff;
    @(posedge clk) disable iff (sys_rst) (tx_disable_pin || soft_off_q) |-> !laser_enable;
  endproperty
  a_shutoff: assert property (p_shutoff) else $error("laser on under shutoff");

  property p_pin_bit;
    @(posedge clk) disable iff (sys_rst) $rose(tx_disable_pin) |-> stat_byte[7] && !laser_enable;
  endproperty
  a_pin_bit: assert property (p_pin_bit) else $error("shutoff bit not mirrored");

endmodule

// >>> bench/ofs_host_model.sv
// host board model: two-wire master with read and write transfers
`timescale 1ns/10ps
module ofs_host_model (
  // clock
  input  wire logic       clk,
  // two-wire pins
  output logic            scl,
  output logic            sda_m,
  input  wire logic       sda,
  // transfer results
  output logic            got,
  output logic [7:0]      got_data,
  output logic            ack_ok
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    got = 1'b0;
    got_data = 8'h00;
    ack_ok = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask
  // data changes only while scl is low
  task automatic bitx(input logic b, output logic s);
    sda_m = b;
    hw(3);
    scl = 1'b1;
    hw(3);
    s = sda;
    scl = 1'b0;
    hw(1);
  endtask
  task automatic start;
    sda_m = 1'b1;
    scl = 1'b1;
    hw(3);
    sda_m = 1'b0;
    hw(3);
    scl = 1'b0;
    hw(2);
  endtask
  task automatic stop;
    sda_m = 1'b0;
    hw(2);
    scl = 1'b1;
    hw(3);
    sda_m = 1'b1;
    hw(3);
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    if (s) ack_ok = 1'b0;
  endtask
  task automatic rd(input logic [7:0] dev, input logic [7:0] ptr);
    logic [7:0] d;
    logic       s;
    ack_ok = 1'b1;
    start;
    wbyte(dev);
    wbyte(ptr);
    start;
    wbyte(dev | 8'h01);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b1, s);
    stop;
    got_data = d;
    got = 1'b1;
    hw(1);
    got = 1'b0;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    ack_ok = 1'b1;
    start;
    wbyte(8'ha2);
    wbyte(ptr);
    wbyte(d);
    stop;
  endtask
endmodule

// >>> bench/test_optical_module_fault_status.sv
// self-checking bench for the fault and status block
`timescale 1ns/10ps
module test_optical_module_fault_status;
  logic       clk, sys_rst, pin, fdet, eye, scl, sda_m, sda_out, sda_oe_n, got, ack_ok;
  logic       en, f_out, f_oe_n, lost;
  logic [7:0] rx, got_data, lv;
  wire        sda = sda_m & (sda_oe_n | sda_out);
  int         failures, checks_done, cyc;
  logic [7:0] exp_q[$];
  initial clk = 1'b0;
  always #50 clk = ~clk;
  ofs_fault_status i_dut (.clk(clk), .sys_rst(sys_rst), .tx_disable_pin(pin), .laser_fault_det(fdet),
    .eye_unsafe(eye), .rx_level(rx), .laser_enable(en), .tx_fault_out(f_out), .tx_fault_oe_n(f_oe_n),
    .receive_signal_lost(lost), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  ofs_host_model i_host (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda), .got(got), .got_data(got_data),
    .ack_ok(ack_ok));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [7:0] sb(input logic p, input logic s, input logic f, input logic l);
    return {p, s, 3'b000, f, l, 1'b0};
  endfunction
  task automatic rd(input logic [7:0] e, input logic [7:0] dev, input logic [7:0] ptr);
    exp_q.push_back(e);
    i_host.rd(dev, ptr);
  endtask
  task automatic wr(input logic [7:0] d);
    i_host.wr(8'h6e, d);
    check(8'(ack_ok), 8'h01);
  endtask
  always @(posedge got) check(got_data, exp_q.pop_front());
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    sys_rst = 1'b1;
    pin = 1'b0; // shutoff pin starts at ground
    fdet = 1'b0;
    eye = 1'b0;
    rx = 8'h80;
    void'($urandom(81));
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check(8'(f_oe_n), 8'h00);
    check(8'(en), 8'h01);
    check(f_out, 1'b0);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      lv = (i < 2) ? 8'(8'h1f + i) : 8'($urandom);
      rx = lv;
      @(negedge clk);
      check(8'(lost), 8'(lv < 8'h20));
    end
    rx = 8'h05;
    @(negedge clk);
    rd(sb(1'b0, 1'b0, 1'b0, 1'b1), 8'ha2, 8'h6e);
    rx = 8'h80;
    $display("signal lost test done");
    fdet = 1'b1;
    #1 check(8'(en), 8'h00);
    @(negedge clk);
    check(8'(f_oe_n), 8'h01);
    fdet = 1'b0;
    repeat (3) @(negedge clk);
    check(8'(f_oe_n), 8'h01);
    check(8'(en), 8'h00);
    rd(sb(1'b0, 1'b0, 1'b1, 1'b0), 8'ha2, 8'h6e);
    pin = 1'b1; // shutoff spacing shortened to keep the run brief
    rd(sb(1'b1, 1'b0, 1'b1, 1'b0), 8'ha2, 8'h6e);
    check(8'(en), 8'h00);
    pin = 1'b0;
    repeat (2) @(negedge clk);
    check(8'(f_oe_n), 8'h00);
    check(8'(en), 8'h01);
    $display("fault latch test done");
    eye = 1'b1;
    #1 check(8'(en), 8'h00);
    @(negedge clk);
    eye = 1'b0;
    @(negedge clk);
    check(8'(f_oe_n), 8'h01);
    wr(8'h40);
    wr(8'h00);
    check(8'(f_oe_n), 8'h00);
    check(8'(en), 8'h01);
    wr(8'h40);
    check(8'(en), 8'h00);
    rd(sb(1'b0, 1'b1, 1'b0, 1'b0), 8'ha2, 8'h6e);
    wr(8'h00);
    check(8'(en), 8'h01);
    $display("soft shutoff test done");
    rd(8'h00, 8'ha2, 8'h10);
    rd(8'hff, 8'ha0, 8'h6e);
    $display("refusal test done");
    fdet = 1'b1;
    @(negedge clk);
    fdet = 1'b0;
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check(8'(f_oe_n), 8'h00);
    check(8'(en), 8'h01);
    $display("power cycle test done");
    conclude;
  end
endmodule
